//--- pkg/fe_regs_pkg.sv
// Constants, field layout and write masks of the front-end register bank.
package fe_regs_pkg;

  // ---------------------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------------------
  localparam logic [4:0] ADDR_BITS  = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADR_GLOBAL_CONTROL       = 8'h00;
  localparam logic [7:0] ADR_LINK_RATE_AND_POWER  = 8'h01;
  localparam logic [7:0] ADR_PATTERN_OFFSET_DELAY = 8'h02;
  localparam logic [7:0] ADR_SERIAL_RATE_GAIN_EN  = 8'h03;
  localparam logic [7:0] ADR_OFFSET_REMOVAL_PRBS  = 8'h04;
  localparam logic [7:0] ADR_CUSTOM_TEST_PATTERN  = 8'h05;
  localparam logic [7:0] ADR_OFFSET_RD_SELECT     = 8'h07;
  localparam logic [7:0] ADR_OFFSET_RD_VALUE      = 8'h08;
  localparam logic [7:0] ADR_DITHER_CONTROL       = 8'h0b;
  localparam logic [7:0] ADR_CH1_GAIN_OFFSET      = 8'h0d;
  localparam logic [7:0] ADR_CH1_OFFSET_SECOND    = 8'h0e;
  localparam logic [7:0] ADR_CH2_GAIN_OFFSET      = 8'h0f;

  // ---------------------------------------------------------------------------
  // Address ranges of the dies
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADC_ADR_LO  = 8'h01;
  localparam logic [7:0] ADC_ADR_HI  = 8'h3c;
  localparam logic [7:0] AMP_ADR_LO  = 8'hc0;
  localparam logic [7:0] AMP_ADR_HI  = 8'hcd;
  localparam logic [7:0] AMP2_OFFSET = 8'h10;

  // ---------------------------------------------------------------------------
  // Global control fields and reset values
  // ---------------------------------------------------------------------------
  localparam int         GC_SOFT_RESET_BIT = 0;
  localparam int         GC_READ_EN_BIT    = 1;
  localparam int         GC_SPLIT_BIT      = 2;
  localparam logic [15:0] REG_RESET_VAL    = 16'h0000;
  localparam int         RD_VALUE_BITS     = 14;

  // ---------------------------------------------------------------------------
  // Storable bits per converter register
  // ---------------------------------------------------------------------------
  localparam logic [15:0] MASK_LINK_RATE_AND_POWER  = 16'h4035;
  localparam logic [15:0] MASK_PATTERN_OFFSET_DELAY = 16'hffff;
  localparam logic [15:0] MASK_SERIAL_RATE_GAIN_EN  = 16'hf700;
  localparam logic [15:0] MASK_OFFSET_REMOVAL_PRBS  = 16'hfff3;
  localparam logic [15:0] MASK_CUSTOM_TEST_PATTERN  = 16'hffff;
  localparam logic [15:0] MASK_OFFSET_RD_SELECT     = 16'hf801;
  localparam logic [15:0] MASK_DITHER_CONTROL       = 16'h0800;
  localparam logic [15:0] MASK_CH_GAIN_OFFSET       = 16'hfbff;
  localparam logic [15:0] MASK_CH_OFFSET_SECOND     = 16'h03ff;

  function automatic logic [15:0] wr_mask(input logic [7:0] adr);
    case (adr)
      ADR_LINK_RATE_AND_POWER:  wr_mask = MASK_LINK_RATE_AND_POWER;
      ADR_PATTERN_OFFSET_DELAY: wr_mask = MASK_PATTERN_OFFSET_DELAY;
      ADR_SERIAL_RATE_GAIN_EN:  wr_mask = MASK_SERIAL_RATE_GAIN_EN;
      ADR_OFFSET_REMOVAL_PRBS:  wr_mask = MASK_OFFSET_REMOVAL_PRBS;
      ADR_CUSTOM_TEST_PATTERN:  wr_mask = MASK_CUSTOM_TEST_PATTERN;
      ADR_OFFSET_RD_SELECT:     wr_mask = MASK_OFFSET_RD_SELECT;
      ADR_DITHER_CONTROL:       wr_mask = MASK_DITHER_CONTROL;
      ADR_CH1_GAIN_OFFSET:      wr_mask = MASK_CH_GAIN_OFFSET;
      ADR_CH1_OFFSET_SECOND:    wr_mask = MASK_CH_OFFSET_SECOND;
      ADR_CH2_GAIN_OFFSET:      wr_mask = MASK_CH_GAIN_OFFSET;
      default:                  wr_mask = 16'h0000;
    endcase
  endfunction

endpackage

//--- hw/serial_frame_rx.sv
// Serial frame receiver: address and data shift-in, readback shift-out.
`timescale 1ns/1ps
`default_nettype none

module serial_frame_rx (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        sen_n,
  output logic             sdout,
  // Frame results
  input  wire logic [15:0] rd_word,
  output logic             addr_done,
  output logic             frame_done,
  output logic [7:0]       addr,
  output logic [15:0]      data
);

  typedef struct packed {
    logic        sclk_q;
    logic [4:0]  cnt;
    logic [23:0] sr;
    logic [15:0] out_sr;
    logic        sdo;
    logic        addr_done;
    logic        frame_done;
    logic [7:0]  addr;
    logic [15:0] data;
  } rx_s;

  rx_s s_r;
  rx_s s_nxt;
  logic rise;
  logic fall;

  assign rise = sclk & ~s_r.sclk_q;
  assign fall = ~sclk & s_r.sclk_q;

  always_comb begin
    s_nxt            = s_r;
    s_nxt.sclk_q     = sclk;
    s_nxt.addr_done  = 1'b0;
    s_nxt.frame_done = 1'b0;
    if (s_r.addr_done) begin
      s_nxt.out_sr = rd_word;
      s_nxt.sdo    = rd_word[15];
    end
    if (sen_n) begin
      s_nxt.cnt = 5'h00;
      s_nxt.sdo = 1'b0;
    end else if (rise && s_r.cnt < fe_regs_pkg::FRAME_BITS) begin
      s_nxt.sr  = {s_r.sr[22:0], sdata};
      s_nxt.cnt = s_r.cnt + 5'h01;
      if (s_r.cnt == fe_regs_pkg::ADDR_BITS - 5'h01) begin
        s_nxt.addr_done = 1'b1;
        s_nxt.addr      = {s_r.sr[6:0], sdata};
      end
      if (s_r.cnt == fe_regs_pkg::FRAME_BITS - 5'h01) begin
        s_nxt.frame_done = 1'b1;
        s_nxt.data       = {s_r.sr[14:0], sdata};
      end
    end else if (fall && s_r.cnt > fe_regs_pkg::ADDR_BITS &&
                 s_r.cnt < fe_regs_pkg::FRAME_BITS) begin
      s_nxt.out_sr = {s_r.out_sr[14:0], 1'b0};
      s_nxt.sdo    = s_r.out_sr[14];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sdout      = s_r.sdo;
  assign addr_done  = s_r.addr_done;
  assign frame_done = s_r.frame_done;
  assign addr       = s_r.addr;
  assign data       = s_r.data;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence addr_phase;
    addr_done ##1 !addr_done;
  endsequence

  a_frame_done_pulse: assert property (@(posedge clk) disable iff (rst)
    frame_done |=> !frame_done)
    else $error("frame done lasted more than one cycle");
  a_addr_load_out: assert property (@(posedge clk) disable iff (rst)
    addr_phase |-> (sen_n || sdout == $past(rd_word[15])))
    else $error("readback word not loaded after address");

endmodule

`default_nettype wire

//--- hw/amp_die_decode.sv
// Write decode for the two amplifier dies, shared or split address range.
`timescale 1ns/1ps
`default_nettype none

module amp_die_decode #(
  parameter logic [7:0] OFFSET = fe_regs_pkg::AMP2_OFFSET
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Decoded frame
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] data,
  input  wire logic        split,
  // Die write strobes
  output logic             wr1,
  output logic             wr2,
  output logic [7:0]       addr_o,
  output logic [15:0]      data_o
);

  typedef struct packed {
    logic        wr1;
    logic        wr2;
    logic [7:0]  addr;
    logic [15:0] data;
  } dec_s;

  dec_s s_r;
  dec_s s_nxt;
  logic in_shared;
  logic in_upper;

  assign in_shared = addr >= fe_regs_pkg::AMP_ADR_LO && addr <= fe_regs_pkg::AMP_ADR_HI;
  assign in_upper  = addr >= fe_regs_pkg::AMP_ADR_LO + OFFSET &&
                     addr <= fe_regs_pkg::AMP_ADR_HI + OFFSET;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.wr1 = 1'b0;
    s_nxt.wr2 = 1'b0;
    if (wr) begin
      if (!split && in_shared) begin
        s_nxt.wr1  = 1'b1;
        s_nxt.wr2  = 1'b1;
        s_nxt.addr = addr;
        s_nxt.data = data;
      end else if (split && in_shared) begin
        s_nxt.wr1  = 1'b1;
        s_nxt.addr = addr;
        s_nxt.data = data;
      end else if (split && in_upper) begin
        s_nxt.wr2  = 1'b1;
        s_nxt.addr = addr - OFFSET;
        s_nxt.data = data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wr1    = s_r.wr1;
  assign wr2    = s_r.wr2;
  assign addr_o = s_r.addr;
  assign data_o = s_r.data;

endmodule

`default_nettype wire

//--- hw/frontend_regs.sv
// Serially programmed global and converter register bank of the front end.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Global control is write-only; only its low three bits act, upper bits ignored.
// - Split bit clear shares amplifier range; set separates the two dies.
// - Global bit 1 enables register readout; clearing it disables readout.
// - Writing one to global bit 0 returns the whole bank to reset.
// - The soft reset bit clears itself; it is never held.
// - Every programmable bit comes out of reset as zero.
// - Converter decodes addresses 1 to 60 as its own.
// - With split clear both amplifier dies take every write to 192..205.
// - Reset pin pulse clears all registers to zero at initialization.
module frontend_regs #(
  parameter logic [7:0] AMP2_OFFSET = fe_regs_pkg::AMP2_OFFSET
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // Serial interface
  input  wire logic        SCLK,
  input  wire logic        SDATA,
  input  wire logic        SEN_N,
  output logic             SDOUT,
  // Offset readback source
  input  wire logic [13:0] OFFSET_VAL,
  // Global control state
  output logic             AMP_SPLIT,
  output logic             READ_EN,
  output logic             SOFT_RESET,
  // Converter configuration
  output logic [15:0]      LINK_RATE_AND_POWER,
  output logic [15:0]      PATTERN_AND_OFFSET_DELAY,
  output logic [15:0]      SERIAL_RATE_GAIN_ENABLE,
  output logic [15:0]      OFFSET_REMOVAL_PRBS_CONFIG,
  output logic [15:0]      CUSTOM_TEST_PATTERN,
  output logic [15:0]      OFFSET_READBACK_SELECT,
  output logic [15:0]      DITHER_CONTROL,
  output logic [15:0]      CH1_GAIN_OFFSET,
  output logic [15:0]      CH1_OFFSET_SECOND,
  output logic [15:0]      CH2_GAIN_OFFSET,
  // Amplifier die writes
  output logic             AMP1_WR,
  output logic             AMP2_WR,
  output logic [7:0]       AMP_ADDR,
  output logic [15:0]      AMP_DATA
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              read_en;
    logic              split;
    logic              soft_pulse;
    logic [15:0][15:0] regs;
  } bank_s;

  bank_s        s_r;
  bank_s        s_nxt;
  logic         addr_done;
  logic         frame_done;
  logic [7:0]   rx_addr;
  logic [15:0]  rx_data;
  logic [15:0]  rd_word;
  logic         adc_hit;
  logic         amp_rst;

  // ---------------------------------------------------------------------------
  // Serial frame receiver
  // ---------------------------------------------------------------------------
  serial_frame_rx u_rx (
    .clk        (CLK_SYS),
    .rst        (RST),
    .sclk       (SCLK),
    .sdata      (SDATA),
    .sen_n      (SEN_N),
    .sdout      (SDOUT),
    .rd_word    (rd_word),
    .addr_done  (addr_done),
    .frame_done (frame_done),
    .addr       (rx_addr),
    .data       (rx_data)
  );

  // ---------------------------------------------------------------------------
  // Address decode and readback
  // ---------------------------------------------------------------------------
  assign adc_hit = rx_addr >= fe_regs_pkg::ADC_ADR_LO &&
                   rx_addr <= fe_regs_pkg::ADC_ADR_HI;

  // Readback returns zero unless readout is enabled; the global word reads as zero.
  always_comb begin
    rd_word = 16'h0000;
    if (s_r.read_en && adc_hit) begin
      if (rx_addr == fe_regs_pkg::ADR_OFFSET_RD_VALUE) begin
        rd_word = {2'b00, OFFSET_VAL};
      end else if (rx_addr[7:4] == 4'h0) begin
        rd_word = s_r.regs[rx_addr[3:0]] & fe_regs_pkg::wr_mask(rx_addr);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  always_comb begin
    s_nxt            = s_r;
    s_nxt.soft_pulse = 1'b0;
    if (frame_done) begin
      if (rx_addr == fe_regs_pkg::ADR_GLOBAL_CONTROL) begin
        if (rx_data[fe_regs_pkg::GC_SOFT_RESET_BIT]) begin
          s_nxt            = '0;
          s_nxt.soft_pulse = 1'b1;
        end else begin
          s_nxt.read_en = rx_data[fe_regs_pkg::GC_READ_EN_BIT];
          s_nxt.split   = rx_data[fe_regs_pkg::GC_SPLIT_BIT];
        end
      end else if (adc_hit && !s_r.read_en && rx_addr[7:4] == 4'h0) begin
        // In readout mode a converter frame is a read and leaves the bank untouched.
        s_nxt.regs[rx_addr[3:0]] = rx_data & fe_regs_pkg::wr_mask(rx_addr);
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Amplifier die write decode
  // ---------------------------------------------------------------------------
  // The decoder is cleared one cycle after the bank, so a soft reset also drops
  // any amplifier strobe and the held amplifier address and data.
  assign amp_rst = RST | s_r.soft_pulse;

  amp_die_decode #(
    .OFFSET (AMP2_OFFSET)
  ) u_amp (
    .clk    (CLK_SYS),
    .rst    (amp_rst),
    .wr     (frame_done),
    .addr   (rx_addr),
    .data   (rx_data),
    .split  (s_r.split),
    .wr1    (AMP1_WR),
    .wr2    (AMP2_WR),
    .addr_o (AMP_ADDR),
    .data_o (AMP_DATA)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign AMP_SPLIT                  = s_r.split;
  assign READ_EN                    = s_r.read_en;
  assign SOFT_RESET                 = s_r.soft_pulse;
  assign LINK_RATE_AND_POWER        = s_r.regs[4'h1];
  assign PATTERN_AND_OFFSET_DELAY   = s_r.regs[4'h2];
  assign SERIAL_RATE_GAIN_ENABLE    = s_r.regs[4'h3];
  assign OFFSET_REMOVAL_PRBS_CONFIG = s_r.regs[4'h4];
  assign CUSTOM_TEST_PATTERN        = s_r.regs[4'h5];
  assign OFFSET_READBACK_SELECT     = s_r.regs[4'h7];
  assign DITHER_CONTROL             = s_r.regs[4'hb];
  assign CH1_GAIN_OFFSET            = s_r.regs[4'hd];
  assign CH1_OFFSET_SECOND          = s_r.regs[4'he];
  assign CH2_GAIN_OFFSET            = s_r.regs[4'hf];

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence global_wr;
    frame_done && rx_addr == fe_regs_pkg::ADR_GLOBAL_CONTROL;
  endsequence

  sequence soft_wr;
    global_wr ##0 rx_data[0];
  endsequence

  sequence amp_shared_wr;
    frame_done && !s_r.split && rx_addr >= fe_regs_pkg::AMP_ADR_LO &&
    rx_addr <= fe_regs_pkg::AMP_ADR_HI;
  endsequence

  // All decode checks see the same one-cycle step from frame end to outputs.
  sequence split_upper_wr;
    frame_done && s_r.split && rx_addr >= fe_regs_pkg::AMP_ADR_LO + AMP2_OFFSET &&
    rx_addr <= fe_regs_pkg::AMP_ADR_HI + AMP2_OFFSET;
  endsequence

  sequence amp_outside_wr;
    frame_done && !s_r.split &&
    (rx_addr < fe_regs_pkg::AMP_ADR_LO || rx_addr > fe_regs_pkg::AMP_ADR_HI);
  endsequence

  sequence adc_map_wr;
    frame_done && adc_hit && !s_r.read_en && rx_addr[7:4] == 4'h0;
  endsequence

  sequence readout_wr;
    frame_done && adc_hit && s_r.read_en;
  endsequence

  a_global_upper_ignored: assert property (@(posedge CLK_SYS) disable iff (RST)
    global_wr ##0 !rx_data[0] |=> $stable(s_r.regs))
    else $error("global write changed converter registers");

  a_split_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
    global_wr ##0 !rx_data[0] |=> AMP_SPLIT == $past(rx_data[2]))
    else $error("split bit not taken from global write");

  a_read_en_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
    global_wr ##0 !rx_data[0] |=> READ_EN == $past(rx_data[1]))
    else $error("readout enable not taken from global write");

  a_soft_clears_all: assert property (@(posedge CLK_SYS) disable iff (RST)
    soft_wr |=> s_r.regs == '0 && !AMP_SPLIT && !READ_EN)
    else $error("soft reset left state behind");

  a_soft_self_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
    soft_wr |=> SOFT_RESET ##1 !SOFT_RESET)
    else $error("soft reset did not clear itself");

  a_reset_zero: assert property (@(posedge CLK_SYS)
    RST |=> s_r.regs == '0 && !AMP_SPLIT && !READ_EN && !SOFT_RESET)
    else $error("register not zero after reset");

  a_adc_not_amp: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_done && adc_hit |=> !AMP1_WR && !AMP2_WR)
    else $error("converter address reached an amplifier die");

  a_amp_shared: assert property (@(posedge CLK_SYS) disable iff (RST)
    amp_shared_wr |=> AMP1_WR && AMP2_WR && AMP_ADDR == $past(rx_addr))
    else $error("shared amplifier write not given to both dies");

  a_pin_reset_amp: assert property (@(posedge CLK_SYS)
    RST |=> !AMP1_WR && !AMP2_WR && AMP_DATA == 16'h0000)
    else $error("amplifier strobes active after reset pin");

  a_split_upper_die: assert property (@(posedge CLK_SYS) disable iff (RST)
    split_upper_wr |=>
    !AMP1_WR && AMP2_WR && AMP_ADDR == $past(rx_addr) - AMP2_OFFSET)
    else $error("upper amplifier address not given to second die");

  a_adc_store: assert property (@(posedge CLK_SYS) disable iff (RST)
    adc_map_wr |=> s_r.regs[$past(rx_addr[3:0])] ==
                   ($past(rx_data) & fe_regs_pkg::wr_mask($past(rx_addr))))
    else $error("converter write not stored");

  a_readout_no_wr: assert property (@(posedge CLK_SYS) disable iff (RST)
    readout_wr |=> $stable(s_r.regs))
    else $error("frame in readout mode changed a register");

  a_outside_ignored: assert property (@(posedge CLK_SYS) disable iff (RST)
    frame_done && !adc_hit && rx_addr != fe_regs_pkg::ADR_GLOBAL_CONTROL |=>
    $stable(s_r.regs))
    else $error("foreign address changed a converter register");

  a_amp_out_range: assert property (@(posedge CLK_SYS) disable iff (RST)
    amp_outside_wr |=> !AMP1_WR && !AMP2_WR)
    else $error("amplifier strobe outside the shared range");

  a_readback_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    !READ_EN |-> rd_word == 16'h0000)
    else $error("readback word not zero with readout off");

  a_readback_value: assert property (@(posedge CLK_SYS) disable iff (RST)
    READ_EN && rx_addr == fe_regs_pkg::ADR_OFFSET_RD_VALUE |->
    rd_word == {2'b00, OFFSET_VAL})
    else $error("offset value not returned");

  a_global_reads_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    rx_addr == fe_regs_pkg::ADR_GLOBAL_CONTROL |-> rd_word == 16'h0000)
    else $error("global control word was readable");

  a_ctrl_holds: assert property (@(posedge CLK_SYS) disable iff (RST)
    !(frame_done && rx_addr == fe_regs_pkg::ADR_GLOBAL_CONTROL) |=>
    $stable(AMP_SPLIT) && $stable(READ_EN))
    else $error("global control bits changed without a global write");

  a_soft_from_global: assert property (@(posedge CLK_SYS) disable iff (RST)
    SOFT_RESET |-> $past(frame_done) && $past(rx_addr) == fe_regs_pkg::ADR_GLOBAL_CONTROL)
    else $error("soft reset pulse without a global write");

  a_soft_amp_clear: assert property (@(posedge CLK_SYS) disable iff (RST)
    SOFT_RESET |=> !AMP1_WR && !AMP2_WR && AMP_ADDR == 8'h00 && AMP_DATA == 16'h0000)
    else $error("soft reset left amplifier outputs behind");

endmodule

`default_nettype wire

//--- test/spi_host_model.sv
// Serial host model that frames register writes and reads for the bank.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  // Clock
  input  wire logic        clk,
  // Request
  input  wire logic        start,
  input  wire logic [7:0]  adr,
  input  wire logic [15:0] wdata,
  input  wire logic [4:0]  nbits,
  input  wire logic [3:0]  half,
  output logic             done,
  output logic [15:0]      rdata,
  // Serial pins
  input  wire logic        sdout,
  output logic             sclk,
  output logic             sdata,
  output logic             sen_n
);
  logic [23:0] word;

  // The serial clock stands low between frames; a released data line shows the inverse.
  initial begin
    done = 1'b0;
    rdata = 16'h0000;
    sclk = 1'b0;
    sdata = 1'b0;
    sen_n = 1'b1;
    forever begin
      @(posedge clk);
      if (start === 1'b1 && done === 1'b0) begin
        @(negedge clk);
        word = {adr, wdata};
        rdata = 16'h0000;
        sen_n = 1'b0;
        for (int i = 0; i < 32'(nbits); i++) begin
          sdata = word[23-i];
          repeat (half) @(negedge clk);
          if (i > 7)
            rdata = {rdata[14:0], sdout};
          sclk = 1'b1;
          repeat (half) @(negedge clk);
          sclk = 1'b0;
        end
        sen_n = 1'b1;
        sdata = ~sdata;
        done = 1'b1;
      end else if (start === 1'b0) begin
        @(negedge clk);
        done = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

//--- test/frontend_regs_bench.sv
// Self-checking bench of the front-end register bank driven by a serial host model.
`timescale 1ns/1ps
`default_nettype none

module frontend_regs_bench;
  localparam logic [7:0]  AMP2_OFF = fe_regs_pkg::AMP2_OFFSET;
  localparam logic [7:0]  ADRS [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h0b,
                                        8'h0d, 8'h0e, 8'h0f};
  localparam logic [15:0] MSKS [10] = '{fe_regs_pkg::MASK_LINK_RATE_AND_POWER,
    fe_regs_pkg::MASK_PATTERN_OFFSET_DELAY, fe_regs_pkg::MASK_SERIAL_RATE_GAIN_EN,
    fe_regs_pkg::MASK_OFFSET_REMOVAL_PRBS, fe_regs_pkg::MASK_CUSTOM_TEST_PATTERN,
    fe_regs_pkg::MASK_OFFSET_RD_SELECT, fe_regs_pkg::MASK_DITHER_CONTROL,
    fe_regs_pkg::MASK_CH_GAIN_OFFSET, fe_regs_pkg::MASK_CH_OFFSET_SECOND,
    fe_regs_pkg::MASK_CH_GAIN_OFFSET};

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, sdata, sen_n, sdout;
  logic [13:0] offset_val = 14'h0000;
  logic        amp_split, read_en, soft_reset, amp1_wr, amp2_wr;
  logic [7:0]  amp_addr;
  logic [15:0] amp_data;
  logic [15:0] cfg [10];
  logic        h_start = 1'b0;
  logic [7:0]  h_adr = 8'h00;
  logic [15:0] h_wdata = 16'h0000;
  logic [4:0]  h_nbits = 5'h18;
  logic [3:0]  h_half = 4'h3;
  logic        h_done;
  logic        done_d = 1'b0;
  logic [15:0] h_rdata;
  logic [15:0] seed = 16'h002d;
  logic [15:0] expv [10];
  logic [15:0] rd_q [$];
  logic [26:0] pl_q [$];
  logic [26:0] seen_pl;
  int          fail_count = 0;
  int          checks_done = 0;

  always #5 clk_sys = ~clk_sys;

  frontend_regs #(.AMP2_OFFSET(AMP2_OFF)) uut (
    .CLK_SYS(clk_sys), .RST(rst), .SCLK(sclk), .SDATA(sdata), .SEN_N(sen_n), .SDOUT(sdout),
    .OFFSET_VAL(offset_val), .AMP_SPLIT(amp_split), .READ_EN(read_en),
    .SOFT_RESET(soft_reset), .LINK_RATE_AND_POWER(cfg[0]), .PATTERN_AND_OFFSET_DELAY(cfg[1]),
    .SERIAL_RATE_GAIN_ENABLE(cfg[2]), .OFFSET_REMOVAL_PRBS_CONFIG(cfg[3]),
    .CUSTOM_TEST_PATTERN(cfg[4]), .OFFSET_READBACK_SELECT(cfg[5]), .DITHER_CONTROL(cfg[6]),
    .CH1_GAIN_OFFSET(cfg[7]), .CH1_OFFSET_SECOND(cfg[8]), .CH2_GAIN_OFFSET(cfg[9]),
    .AMP1_WR(amp1_wr), .AMP2_WR(amp2_wr), .AMP_ADDR(amp_addr), .AMP_DATA(amp_data));

  spi_host_model host (
    .clk(clk_sys), .start(h_start), .adr(h_adr), .wdata(h_wdata), .nbits(h_nbits),
    .half(h_half), .done(h_done), .rdata(h_rdata), .sdout(sdout), .sclk(sclk),
    .sdata(sdata), .sen_n(sen_n));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic frame(input logic [7:0] a, input logic [15:0] d, input logic [4:0] n,
                       input logic [15:0] rd);
    rd_q.push_back(rd);
    @(negedge clk_sys);
    h_adr = a;
    h_wdata = d;
    h_nbits = n;
    h_start = 1'b1;
    for (int k = 0; k < 2000 && h_done !== 1'b1; k++)
      @(posedge clk_sys);
    if (h_done !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
    @(negedge clk_sys);
    h_start = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic amp_wr(input logic [7:0] a, input logic [2:0] hit, input logic [7:0] ea);
    seed = lfsr(seed);
    if (hit != 3'b000)
      pl_q.push_back({hit, ea, seed});
    frame(a, seed, 5'h18, 16'h0000);
  endtask

  task automatic check_zero();
    for (int i = 0; i < 10; i++)
      check(32'(cfg[i]), 32'h0);
    check(32'({amp_split, read_en, soft_reset, amp1_wr, amp2_wr, amp_addr, amp_data}), 32'h0);
  endtask

  // The watcher takes the oldest note whenever a frame ends or a strobe pulses.
  always @(posedge clk_sys) begin
    if (h_done === 1'b1 && done_d === 1'b0)
      check(32'(h_rdata), 32'(rd_q.size() ? rd_q.pop_front() : 16'h0000));
    done_d <= h_done;
    if ((soft_reset | amp1_wr | amp2_wr) === 1'b1) begin
      seen_pl = soft_reset ? {3'b100, 24'h0} : {1'b0, amp1_wr, amp2_wr, amp_addr, amp_data};
      check(32'(seen_pl), 32'(pl_q.size() ? pl_q.pop_front() : 27'h0));
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check_zero();
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      expv[i] = seed & MSKS[i];
      frame(ADRS[i], seed, 5'h18, 16'h0000);
      check(32'(cfg[i]), 32'(expv[i]));
    end
    frame(8'h3c, 16'hffff, 5'h18, 16'h0000);
    frame(8'h00, 16'h0002, 5'h18, 16'h0000);
    check(32'(read_en), 32'h1);
    h_half = 4'h7;
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      frame(ADRS[i], seed, 5'h18, expv[i]);
      check(32'(cfg[i]), 32'(expv[i]));
    end
    offset_val = seed[13:0];
    frame(8'h08, 16'h0000, 5'h18, {2'b00, offset_val});
    frame(8'h3c, 16'h0000, 5'h18, 16'h0000);
    frame(8'h00, 16'h0000, 5'h18, 16'h0000);
    check(32'(read_en), 32'h0);
    frame(8'h00, 16'hfff8, 5'h18, 16'h0000);
    check(32'({amp_split, read_en, cfg[1]}), 32'(expv[1]));
    amp_wr(8'hc0, 3'b011, 8'hc0);
    amp_wr(8'hcd, 3'b011, 8'hcd);
    amp_wr(8'hbf, 3'b000, 8'h00);
    amp_wr(8'hce, 3'b000, 8'h00);
    frame(8'h00, 16'h0004, 5'h18, 16'h0000);
    check(32'(amp_split), 32'h1);
    amp_wr(8'hd5, 3'b001, 8'hd5 - AMP2_OFF);
    amp_wr(8'hd9, 3'b001, 8'hd9 - AMP2_OFF);
    frame(8'h00, 16'h0000, 5'h18, 16'h0000);
    frame(ADRS[1], ~expv[1], 5'h0a, 16'h0000);
    check(32'(cfg[1]), 32'(expv[1]));
    h_half = 4'h3;
    pl_q.push_back({3'b100, 24'h0});
    frame(8'h00, 16'h0003, 5'h18, 16'h0000);
    check_zero();
    frame(ADRS[1], 16'hffff, 5'h18, 16'h0000);
    check(32'(cfg[1]), 32'hffff);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check_zero();
    check(32'(pl_q.size() + rd_q.size()), 32'h0);
    print_verdict();
  end

  initial begin
    #300000;
    fail_count++;
    print_verdict();
  end
endmodule

`default_nettype wire
